//--- inc/usu_pkg.sv
// shared constants and types for the universal serial shift unit
package usu_pkg;

	// datapath sizes
	localparam int        DATA_BITS  = 8;     // shift register width
	localparam int        CNT_BITS   = 4;     // edge counter width
	localparam int        MSB_IDX    = 7;     // serial output bit of the register

	// reset and wrap values
	localparam logic [7:0] DATA_RESET = 8'h00; // shift register after reset
	localparam logic [3:0] CNT_RESET  = 4'h0;  // counter after reset
	localparam logic [3:0] CNT_WRAP   = 4'hf;  // last count before overflow
	localparam logic [3:0] CNT_ONE    = 4'h1;  // counter step

	// wire modes as given on the wire mode select port
	typedef enum logic [1:0]
	{
		WM_OFF   = 2'h0,                   // outputs released
		WM_THREE = 2'h1,                   // spi style shifter
		WM_TWO   = 2'h2,                   // i2c style physical layer
		WM_TWO_B = 2'h3                    // same as two-wire
	} usu_wire_e;

	// start hold sequence, gray coded along the usual path
	typedef enum logic [1:0]
	{
		HS_IDLE  = 2'b00,                  // no start pending
		HS_ARMED = 2'b01,                  // start seen, waiting for scl fall
		HS_HELD  = 2'b11                   // scl held low
	} usu_hold_e;

	// timing
	localparam int SYS_CLK_MHZ    = 20;   // system clock rate
	localparam int SYS_PERIOD_NS  = 1000 / SYS_CLK_MHZ;
	localparam int SCK_DIV_MIN    = 4;    // serial clock at most sys clock / 4
	localparam int LINK_PERIOD_NS = 6;    // start detector sampling clock
	localparam int SDA_DLY_MIN_NS = 50;   // least sda delay
	localparam int SDA_DLY_MAX_NS = 300;  // longest sda delay
	localparam int SDA_DLY_STAGES =
		(SDA_DLY_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

endpackage

//--- inc/usu_link_if.sv
// signals between the core and the start detector
`timescale 1ns/1ns
interface usu_link_if;
	logic scl_raw;   // scl pin level, unsynchronised
	logic sda_raw;   // sda pin level, unsynchronised
	logic twi_en;    // two-wire mode, system clock level
	logic ce_lvl;    // clock enable, system clock level
	logic start_tgl; // flips once per detected start, link clock

	modport core
	(
		output scl_raw,
		output sda_raw,
		output twi_en,
		output ce_lvl,
		input  start_tgl
	);

	modport det
	(
		input  scl_raw,
		input  sda_raw,
		input  twi_en,
		input  ce_lvl,
		output start_tgl
	);
endinterface

//--- hdl/usu_start_det.sv
// start condition detector on the link sampling clock
`timescale 1ns/1ns
module usu_start_det
	import usu_pkg::*;
#(
	parameter int DLY_STAGES = SDA_DLY_STAGES // sda delay length
)
(
	input wire logic link_clk, // detector sampling clock
	input wire logic rst,      // asynchronous reset, high
	usu_link_if.det  lnk       // to and from the core
);
	logic                  scl_m_q;   // scl first stage
	logic                  scl_s_q;   // scl second stage
	logic                  sda_m_q;   // sda first stage
	logic                  sda_s_q;   // sda second stage
	logic                  en_m_q;    // mode first stage
	logic                  en_s_q;    // mode second stage
	logic                  ce_m_q;    // enable first stage
	logic                  ce_s_q;    // enable second stage
	logic [DLY_STAGES-1:0] dly_q;     // delayed copies of sda
	logic                  tgl_q;     // start event toggle
	logic                  sda_fell;  // delayed sda falling
	logic                  start_hit; // start seen this cycle

	// sda falls in the delayed copy while scl is still high
	assign sda_fell  = dly_q[DLY_STAGES-1] & ~dly_q[DLY_STAGES-2];
	assign start_hit = en_s_q & scl_s_q & sda_fell;     // RULE_13 RULE_20
	assign lnk.start_tgl = tgl_q;

	// synchronisers; mode and enable are levels from the other domain
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			{scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hf;
			{en_m_q, en_s_q, ce_m_q, ce_s_q} <= 4'h0;
		end
		else
		begin
			{scl_m_q, scl_s_q} <= {lnk.scl_raw, scl_m_q};
			{sda_m_q, sda_s_q} <= {lnk.sda_raw, sda_m_q};
			{en_m_q, en_s_q} <= {lnk.twi_en, en_m_q};
			{ce_m_q, ce_s_q} <= {lnk.ce_lvl, ce_m_q};
		end
	end

	// delay line lets scl settle before it is judged; no system clock
	// is needed here, but the line and toggle stop while CE is low, so no start is caught then
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			dly_q <= '1;
		else if (ce_s_q)
			dly_q <= {dly_q[DLY_STAGES-2:0], sda_s_q};  // RULE_20 RULE_21
	end

	// one flip per start, carried to the core as a toggle
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			tgl_q <= 1'b0;
		else if (ce_s_q && start_hit)
			tgl_q <= ~tgl_q;                               // RULE_21
	end
endmodule

//--- hdl/usu_core.sv
// universal serial shift unit: shifter, counter, flags and clock hold
//
// Function
// RULE_01: three-wire mode is spi modes 0/1, no select
// RULE_02: one clock drives shift register and counter
// RULE_03: external clock counts both edges, sixteen per byte
// RULE_04: toggle strobe flips the shift clock pin
// RULE_05: edge select 0 samples rising, shifts falling
// RULE_06: edge select 1 samples falling, shifts rising
// RULE_07: data and driver ready half clock before sampling
// RULE_08: software zeroes counter before each byte
// RULE_09: overflow flag can wake from idle sleep
// RULE_10: two-wire layer without slew limit or filter
// RULE_11: master clocks in software, slave holds clock
// RULE_12: master checks scl really went high
// RULE_13: sda low while scl high sets start flag
// RULE_14: master pulls sda via bit 7 or port; here bit 7 only, there is no data port
// RULE_15: after start, scl fall held until released
// RULE_16: two-wire samples sda on rising scl
// RULE_17: after eight bits overflow holds scl low
// RULE_18: acknowledge by presetting counter to fourteen
// RULE_19: several bytes follow until stop or restart
// RULE_20: detector only in two-wire, uses delayed sda
// RULE_21: start detector runs without the system clock; here it stops while CE is low
// RULE_22: serial clock at most system clock over four
// RULE_23: overflow flag sets on wrap, clear releases scl
// RULE_24: start flag cleared by writing one, releases scl
// RULE_25: output pin from bit 7 through a latch
// RULE_26: register write beats a coinciding shift
`timescale 1ns/1ns
module usu_core
	import usu_pkg::*;
#(
	parameter int         DATA_W   = DATA_BITS, // shift register width
	parameter int         CNT_W    = CNT_BITS,  // counter width
	parameter logic       CLK_INIT = 1'b0       // clock port after reset
)
(
	input  wire logic              SYS_CLK,               // system clock
	input  wire logic              RST,                   // async reset, high
	input  wire logic              CE,                    // clock enable
	input  wire logic              LINK_CLK,              // detector clock
	input  wire logic [1:0]        WIRE_MODE_SELECT,      // wire mode
	input  wire logic              EXTERNAL_CLOCK_SELECT, // pin clocks shifter
	input  wire logic              CLOCK_EDGE_SELECT,     // edge / source sel
	input  wire logic              CLOCK_STROBE_SELECT,   // count on toggles
	input  wire logic              DATA_DIR_DATA,         // data pin output on
	input  wire logic              DATA_DIR_CLOCK,        // clock pin output on
	input  wire logic              SHIFT_DATA_WR,         // register write
	input  wire logic [DATA_W-1:0] SHIFT_DATA_WDATA,      // register value
	input  wire logic              COUNT_WR,              // counter write
	input  wire logic [CNT_W-1:0]  COUNT_WDATA,           // counter value
	input  wire logic              CLOCK_TOGGLE_STROBE,   // toggle clock pin
	input  wire logic              CLOCK_STROBE,          // software clock
	input  wire logic              TIMER_MATCH,           // timer clock
	input  wire logic              OVERFLOW_CLEAR,        // clear overflow
	input  wire logic              START_CLEAR,           // clear start flag
	input  wire logic              SERIAL_INPUT_PIN,      // data in / sda
	input  wire logic              SHIFT_CLOCK_PIN_I,     // clock pin level
	output logic                   SHIFT_CLOCK_PIN_O,     // clock pin drive
	output logic                   SHIFT_CLOCK_PIN_OE_N,  // clock pin enable
	output logic                   DATA_OUT_PIN_O,        // data out drive
	output logic                   DATA_OUT_PIN_OE_N,     // data out enable
	output logic [DATA_W-1:0]      SHIFT_DATA_REGISTER,   // register value
	output logic [CNT_W-1:0]       COUNT_VALUE,           // counter value
	output logic                   COUNTER_OVERFLOW_FLAG, // byte done
	output logic                   START_DETECT_FLAG,     // start seen
	output logic                   IDLE_WAKE              // wake request
);
	usu_link_if lnk ();                      // path to start detector

	// pin synchronisers and event sync
	logic               sck_m_q;            // clock pin first stage
	logic               sck_s_q;            // clock pin second stage
	logic               sck_p_q;            // clock pin previous level
	logic               din_m_q;            // data pin first stage
	logic               din_s_q;            // data pin second stage
	logic               tgl_m_q;            // start toggle first stage
	logic               tgl_s_q;            // start toggle second stage
	logic               tgl_p_q;            // start toggle previous

	// block state
	logic [DATA_W-1:0]  sr_q;               // shift register
	logic [DATA_W-1:0]  sr_d;
	logic [CNT_W-1:0]   cnt_q;              // edge counter
	logic [CNT_W-1:0]   cnt_d;
	logic               smp_q;              // sampled serial bit
	logic               open_q;             // output latch open
	logic               dlat_q;             // output latch
	logic               ovf_q;              // overflow flag
	logic               stf_q;              // start flag
	logic               port_q;             // clock port value
	logic               twi_q;              // two-wire mode level
	usu_hold_e          hold_q;             // start hold sequence
	usu_hold_e          hold_d;
	logic               sclo_q;             // clock pin drive reg
	logic               scloe_n_q;          // clock pin enable reg
	logic               dout_q;             // data pin drive reg
	logic               doe_n_q;            // data pin enable reg

	// decoded events
	logic               clk_rise;           // clock pin rose
	logic               clk_fall;           // clock pin fell
	logic               ext_clk;            // pin clocks the shifter
	logic               is_three;           // three-wire mode
	logic               is_two;             // two-wire mode
	logic               sample_ev;          // capture serial input
	logic               shift_ev;           // shift on pin edge
	logic               int_ev;             // internal clock event
	logic               count_ev;           // counter step
	logic               wrap_ev;            // counter wraps to zero
	logic               start_ev;           // start reached this domain
	logic               scl_hold;           // slave holds scl low
	logic               latch_open;         // output latch transparent
	logic               sclo_d;
	logic               scloe_n_d;
	logic               dout_d;
	logic               doe_n_d;

	// counter step with wrap by width
	function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] v);
		cnt_step = v + CNT_ONE[CNT_W-1:0];
	endfunction

	// link to the detector; raw pins are synchronised over there
	assign lnk.scl_raw = SHIFT_CLOCK_PIN_I;
	assign lnk.sda_raw = SERIAL_INPUT_PIN;
	assign lnk.twi_en  = twi_q;                         // RULE_20
	assign lnk.ce_lvl  = CE;

	usu_start_det #(
		.DLY_STAGES (SDA_DLY_STAGES)
	) u_det (
		.link_clk (LINK_CLK),
		.rst      (RST),
		.lnk      (lnk.det)
	);

	// mode decode; no select pin exists in three-wire mode
	assign is_three = (WIRE_MODE_SELECT == WM_THREE);   // RULE_01
	assign is_two   = WIRE_MODE_SELECT[1];              // RULE_10
	assign ext_clk  = EXTERNAL_CLOCK_SELECT;

	// edges come from the second sync stage; the two-stage delay is
	// why the serial clock must stay at or below sys clock / 4
	assign clk_rise = sck_s_q & ~sck_p_q;               // RULE_22
	assign clk_fall = ~sck_s_q & sck_p_q;

	// edge select picks which pin edge samples and which shifts
	assign sample_ev = ext_clk &
		(CLOCK_EDGE_SELECT ? clk_fall : clk_rise);      // RULE_05 RULE_06
	assign shift_ev  = ext_clk &
		(CLOCK_EDGE_SELECT ? clk_rise : clk_fall);      // RULE_05 RULE_06

	// internal source: software strobe or timer match
	assign int_ev = ~ext_clk &
		(CLOCK_EDGE_SELECT ? TIMER_MATCH : CLOCK_STROBE);

	// same source steps the counter; external counts every edge unless
	// the toggle strobe is chosen to count instead
	assign count_ev = ext_clk ?
		(CLOCK_STROBE_SELECT ? CLOCK_TOGGLE_STROBE
		                     : (clk_rise | clk_fall))   // RULE_03
		: int_ev;                                       // RULE_02
	assign wrap_ev  = count_ev & ~COUNT_WR &
		(cnt_q == CNT_WRAP[CNT_W-1:0]);                 // RULE_23 RULE_03

	assign start_ev = twi_q & (tgl_s_q ^ tgl_p_q);      // RULE_13

	// shift register: a write wins over any coinciding shift
	assign sr_d = SHIFT_DATA_WR ? SHIFT_DATA_WDATA       // RULE_26
		: shift_ev ? {sr_q[DATA_W-2:0], smp_q}           // RULE_02
		: int_ev   ? {sr_q[DATA_W-2:0], din_s_q}
		: sr_q;

	// counter: software preset wins, e.g. fourteen before an ack bit
	assign cnt_d = COUNT_WR ? COUNT_WDATA                // RULE_18 RULE_08
		: count_ev ? cnt_step(cnt_q)
		: cnt_q;

	// start hold sequence: armed by a start, held from the next scl fall
	always_comb
	begin
		hold_d = hold_q;
		case (hold_q)
			HS_IDLE:
				if (start_ev)
					hold_d = HS_ARMED;
			HS_ARMED:                                   // RULE_15
				if (!stf_q && !start_ev)
					hold_d = HS_IDLE;
				else if (clk_fall)
					hold_d = HS_HELD;
			HS_HELD:
				if (!stf_q && !start_ev)
					hold_d = HS_IDLE;                   // RULE_24
			default:
				hold_d = HS_IDLE;
		endcase
		if (!twi_q)
			hold_d = HS_IDLE;
	end

	// only the slave side holds scl; both holds are two-wire only
	assign scl_hold = twi_q &
		((hold_q == HS_HELD) | ovf_q);                  // RULE_11 RULE_17

	// latch open from the shift edge to the next sample edge, always
	// open with an internal clock, so output changes opposite sampling
	assign latch_open = ~ext_clk | open_q;              // RULE_25

	// pin drive: push-pull in three-wire, open drain in two-wire
	assign sclo_d    = is_three ? port_q : 1'b0;
	assign scloe_n_d = is_three ? ~DATA_DIR_CLOCK
		: is_two ? ~((DATA_DIR_CLOCK & ~port_q) | scl_hold)
		: 1'b1;
	assign dout_d    = is_three ? dlat_q : 1'b0;
	assign doe_n_d   = is_three ? ~DATA_DIR_DATA         // RULE_07
		: is_two ? ~(DATA_DIR_DATA & ~dlat_q)           // RULE_14
		: 1'b1;

	// pin and start toggle synchronisers
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			{sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
			{din_m_q, din_s_q} <= 2'h0;
			{tgl_m_q, tgl_s_q, tgl_p_q} <= 3'h0;
		end
		else if (CE)
		begin
			{sck_m_q, sck_s_q, sck_p_q} <= {SHIFT_CLOCK_PIN_I, sck_m_q, sck_s_q};
			{din_m_q, din_s_q} <= {SERIAL_INPUT_PIN, din_m_q};
			{tgl_m_q, tgl_s_q, tgl_p_q} <= {lnk.start_tgl, tgl_m_q, tgl_s_q};
		end
	end

	// shift register, counter and sampled bit
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			sr_q  <= DATA_RESET[DATA_W-1:0];
			cnt_q <= CNT_RESET[CNT_W-1:0];
			smp_q <= 1'b0;
		end
		else if (CE)
		begin
			sr_q  <= sr_d;
			cnt_q <= cnt_d;
			if (sample_ev)
				smp_q <= din_s_q;                       // RULE_16
		end
	end

	// output latch follows bit 7 only while open
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			open_q <= 1'b1;
			dlat_q <= 1'b0;
		end
		else if (CE)
		begin
			if (shift_ev)
				open_q <= 1'b1;
			else if (sample_ev)
				open_q <= 1'b0;
			if (latch_open)
				dlat_q <= sr_q[MSB_IDX];                // RULE_25
		end
	end

	// flags: a setting event beats a clear in the same cycle
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			ovf_q <= 1'b0;
			stf_q <= 1'b0;
		end
		else if (CE)
		begin
			ovf_q <= wrap_ev | (ovf_q & ~OVERFLOW_CLEAR);   // RULE_23 RULE_19
			stf_q <= start_ev | (stf_q & ~START_CLEAR);     // RULE_24
		end
	end

	// clock port, mode level and hold sequence
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			port_q <= CLK_INIT;
			twi_q  <= 1'b0;
			hold_q <= HS_IDLE;
		end
		else if (CE)
		begin
			port_q <= port_q ^ CLOCK_TOGGLE_STROBE;     // RULE_04
			twi_q  <= is_two;
			hold_q <= hold_d;
		end
	end

	// registered pin drives; released during reset
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			sclo_q    <= 1'b0;
			scloe_n_q <= 1'b1;
			dout_q    <= 1'b0;
			doe_n_q   <= 1'b1;
		end
		else if (CE)
		begin
			sclo_q    <= sclo_d;
			scloe_n_q <= scloe_n_d;                     // RULE_15 RULE_17
			dout_q    <= dout_d;
			doe_n_q   <= doe_n_d;
		end
	end

	// outputs straight from flops; overflow flag doubles as idle wake
	assign SHIFT_CLOCK_PIN_O     = sclo_q;
	assign SHIFT_CLOCK_PIN_OE_N  = scloe_n_q;
	assign DATA_OUT_PIN_O        = dout_q;
	assign DATA_OUT_PIN_OE_N     = doe_n_q;
	assign SHIFT_DATA_REGISTER   = sr_q;
	assign COUNT_VALUE           = cnt_q;
	assign COUNTER_OVERFLOW_FLAG = ovf_q;
	assign START_DETECT_FLAG     = stf_q;
	assign IDLE_WAKE             = ovf_q;               // RULE_09
endmodule

//--- tb/usu_core_checker.sv
// concurrent checks on the serial shift unit top ports
`timescale 1ns/1ns
module usu_core_checker
#(
	parameter int DATA_W = 8, // register width
	parameter int CNT_W  = 4  // counter width
)
(
	input wire logic              SYS_CLK,               // clock
	input wire logic              RST,                   // reset
	input wire logic              CE,                    // enable
	input wire logic [1:0]        WIRE_MODE_SELECT,      // mode
	input wire logic              EXTERNAL_CLOCK_SELECT, // pin clock
	input wire logic              DATA_DIR_DATA,         // data dir
	input wire logic              DATA_DIR_CLOCK,        // clock dir
	input wire logic              SHIFT_DATA_WR,         // reg write
	input wire logic [DATA_W-1:0] SHIFT_DATA_WDATA,      // reg value
	input wire logic              COUNT_WR,              // cnt write
	input wire logic [CNT_W-1:0]  COUNT_WDATA,           // cnt value
	input wire logic              CLOCK_TOGGLE_STROBE,   // toggle
	input wire logic              OVERFLOW_CLEAR,        // ovf clear
	input wire logic              START_CLEAR,           // start clear
	input wire logic              SHIFT_CLOCK_PIN_O,     // clock drive
	input wire logic              SHIFT_CLOCK_PIN_OE_N,  // clock enable
	input wire logic              DATA_OUT_PIN_O,        // data drive
	input wire logic              DATA_OUT_PIN_OE_N,     // data enable
	input wire logic [DATA_W-1:0] SHIFT_DATA_REGISTER,   // register
	input wire logic [CNT_W-1:0]  COUNT_VALUE,           // counter
	input wire logic              COUNTER_OVERFLOW_FLAG, // byte done
	input wire logic              START_DETECT_FLAG,     // start seen
	input wire logic              IDLE_WAKE              // wake
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	// a write to the counter is excluded, only a count may wrap
	chk_wrap_sets_ovf: assert property
		(&$past(COUNT_VALUE) && COUNT_VALUE == '0 && !$past(COUNT_WR)
		|-> COUNTER_OVERFLOW_FLAG) else $error("wrap left flag low");
	chk_ovf_sticky: assert property
		(COUNTER_OVERFLOW_FLAG && !OVERFLOW_CLEAR |=> COUNTER_OVERFLOW_FLAG)
		else $error("overflow flag dropped");
	chk_start_sticky: assert property
		(START_DETECT_FLAG && !START_CLEAR |=> $stable(START_DETECT_FLAG))
		else $error("start flag dropped");
	chk_wake_follows: assert property
		(IDLE_WAKE == COUNTER_OVERFLOW_FLAG) else $error("wake mismatch");
	chk_write_wins: assert property
		(CE && SHIFT_DATA_WR |=> SHIFT_DATA_REGISTER == $past(SHIFT_DATA_WDATA))
		else $error("register write lost");
	chk_count_load: assert property
		(CE && COUNT_WR |=> COUNT_VALUE == $past(COUNT_WDATA))
		else $error("counter write lost");
	// hold must follow a new overflow while in two-wire mode
	chk_ovf_hold: assert property
		($rose(COUNTER_OVERFLOW_FLAG) && WIRE_MODE_SELECT[1]
		|-> ##[0:3] !SHIFT_CLOCK_PIN_OE_N) else $error("no overflow hold");
	chk_hold_release: assert property
		(CE && WIRE_MODE_SELECT[1] && !DATA_DIR_CLOCK && START_CLEAR
		&& !COUNTER_OVERFLOW_FLAG |-> ##[1:4] SHIFT_CLOCK_PIN_OE_N)
		else $error("start hold not released");
	chk_toggle_pin: assert property
		(CE && WIRE_MODE_SELECT == 2'h1 && CLOCK_TOGGLE_STROBE
		|-> ##2 SHIFT_CLOCK_PIN_O != $past(SHIFT_CLOCK_PIN_O))
		else $error("clock pin did not toggle");
	// internal clock keeps the latch open, so pin shows the msb
	chk_msb_out: assert property
		((CE && WIRE_MODE_SELECT == 2'h1 && !EXTERNAL_CLOCK_SELECT
		&& $stable(SHIFT_DATA_REGISTER)) [*3]
		|-> DATA_OUT_PIN_O == SHIFT_DATA_REGISTER[DATA_W-1])
		else $error("data pin not msb");
	chk_data_enable: assert property
		((CE && WIRE_MODE_SELECT == 2'h1 && DATA_DIR_DATA) [*3]
		|-> !DATA_OUT_PIN_OE_N) else $error("data driver off");

	// main scenarios seen
	cov_spi_byte: cover property
		($rose(COUNTER_OVERFLOW_FLAG) && WIRE_MODE_SELECT == 2'h1);
	cov_start_seen: cover property ($rose(START_DETECT_FLAG));
	cov_ack_hold: cover property
		($rose(COUNTER_OVERFLOW_FLAG) && DATA_DIR_DATA && WIRE_MODE_SELECT[1]);
endmodule

//--- tb/usu_peer.sv
// far-side bus master model, spi and two-wire
`timescale 1ns/1ns
module usu_peer
(
	input wire logic clk,   // timing reference
	input wire logic miso,  // data from the unit
	input wire logic scl_w, // resolved clock wire
	input wire logic sda_w, // resolved data wire
	output logic     clk_o, // clock drive, 1 releases
	output logic     dat_o  // data drive, 1 releases
);
	// slow half period keeps the clock far under system over four
	localparam int HALF = 8;

	initial
	begin
		clk_o = 1'b0;
		dat_o = 1'b1;
	end

	// one half period, moved off the edge
	task half();
		repeat (HALF) @(posedge clk);
		#2;
	endtask

	// software clocked byte; idle level sets which edge samples
	task spi(input logic [7:0] tx, input logic md, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			dat_o = tx[i];
			half();
			clk_o = ~md;
			rx[i] = miso;
			half();
			clk_o = md;
		end
		half();
	endtask

	// data pulled low with clock high, then clock low
	task start();
		dat_o = 1'b0;
		half();
		clk_o = 1'b0;
		half();
	endtask

	// one bit; a held clock is waited out, but not for ever
	task bit_x(input logic b, output logic s);
		dat_o = b;
		half();
		clk_o = 1'b1;
		for (int n = 0; n < 200 && !scl_w; n++)
			@(posedge clk);
		#2;
		s = sda_w;
		half();
		clk_o = 1'b0;
		half();
	endtask
endmodule

//--- tb/usu_core_tb.sv
// self-checking bench for the universal serial shift unit
`timescale 1ns/1ns
`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("mismatch at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module usu_core_tb;
	logic       sys_clk = 1'b0;  // system clock
	logic       link_clk = 1'b0; // detector clock
	logic       rst = 1'b1;      // reset
	logic [1:0] mode = 2'h0;     // wire mode
	logic       ext = 1'b0;      // pin clock
	logic       esel = 1'b0;     // edge select
	logic       ssel = 1'b0;     // count toggles
	logic       dir_d = 1'b0;    // data direction
	logic       dir_c = 1'b0;    // clock direction
	logic       sr_wr = 1'b0;    // register write
	logic [7:0] sr_wd = 8'h00;   // register value
	logic       cnt_wr = 1'b0;   // counter write
	logic [3:0] cnt_wd = 4'h0;   // counter value
	logic       tgl = 1'b0;      // clock toggle
	logic       stb = 1'b0;      // software clock
	logic       ovf_clr = 1'b0;  // overflow clear
	logic       st_clr = 1'b0;   // start clear
	logic       c_o, c_oe_n, d_o, d_oe_n, ovf, stf, wake; // outputs
	logic [7:0] sr;              // register
	logic [3:0] cnt;             // counter
	logic       p_clk, p_dat;    // partner drives
	logic [7:0] rx;              // byte at partner
	logic       s;               // bit at partner
	int         n_errors = 0;    // mismatches
	int         checks = 0;      // comparisons
	int         cycles = 0;      // timeout count
	// pulled-up scl and sda wires; miso reads a released data pin as the inverted drive
	wire        scl_w = (c_oe_n | c_o) & p_clk;
	wire        sda_w = (d_oe_n | d_o) & p_dat;
	wire        sin = mode[1] ? sda_w : p_dat;
	wire        miso = d_oe_n ? ~d_o : d_o;

	always #25 sys_clk = ~sys_clk;
	always #3 link_clk = ~link_clk;

	usu_core i_dut
	(
		.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .LINK_CLK(link_clk),
		.WIRE_MODE_SELECT(mode), .EXTERNAL_CLOCK_SELECT(ext),
		.CLOCK_EDGE_SELECT(esel), .CLOCK_STROBE_SELECT(ssel),
		.DATA_DIR_DATA(dir_d), .DATA_DIR_CLOCK(dir_c),
		.SHIFT_DATA_WR(sr_wr), .SHIFT_DATA_WDATA(sr_wd),
		.COUNT_WR(cnt_wr), .COUNT_WDATA(cnt_wd),
		.CLOCK_TOGGLE_STROBE(tgl), .CLOCK_STROBE(stb), .TIMER_MATCH(1'b0),
		.OVERFLOW_CLEAR(ovf_clr), .START_CLEAR(st_clr),
		.SERIAL_INPUT_PIN(sin), .SHIFT_CLOCK_PIN_I(scl_w),
		.SHIFT_CLOCK_PIN_O(c_o), .SHIFT_CLOCK_PIN_OE_N(c_oe_n),
		.DATA_OUT_PIN_O(d_o), .DATA_OUT_PIN_OE_N(d_oe_n),
		.SHIFT_DATA_REGISTER(sr), .COUNT_VALUE(cnt),
		.COUNTER_OVERFLOW_FLAG(ovf), .START_DETECT_FLAG(stf), .IDLE_WAKE(wake)
	);

	usu_peer i_peer
	(
		.clk(sys_clk), .miso(miso), .scl_w(scl_w), .sda_w(sda_w),
		.clk_o(p_clk), .dat_o(p_dat)
	);

	// hang guard, far above the run length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	// register and counter writes, a free edge after each
	task wr(input logic [7:0] d, input logic [3:0] c, input logic wd, wc);
		sr_wd = d;
		cnt_wd = c;
		sr_wr = wd;
		cnt_wr = wc;
		cyc(1);
		sr_wr = 1'b0;
		cnt_wr = 1'b0;
		cyc(1);
	endtask

	task clr();
		ovf_clr = 1'b1;
		st_clr = 1'b1;
		cyc(1);
		ovf_clr = 1'b0;
		st_clr = 1'b0;
		cyc(1);
	endtask

	// software clock, open latch, write beats a shift
	task t_internal();
		mode = 2'h1;
		dir_d = 1'b1;
		i_peer.dat_o = 1'b0;
		wr(8'h81, 4'h0, 1'b1, 1'b0);
		cyc(3);
		`CHK(d_o, 1'b1)
		stb = 1'b1;
		cyc(1);
		stb = 1'b0;
		cyc(3);
		`CHK(sr, 8'h02)
		`CHK(d_o, 1'b0)
		stb = 1'b1;
		wr(8'h5a, 4'h0, 1'b1, 1'b0);
		stb = 1'b0;
		`CHK(sr, 8'hb4)
	endtask

	// unit as slave against the partner, first edge samples
	task t_spi(input logic md, input logic [7:0] mine, theirs);
		ext = 1'b1;
		esel = md;
		i_peer.clk_o = md;
		cyc(4);
		wr(mine, 4'h0, 1'b1, 1'b1);
		clr();
		cyc(6);
		i_peer.spi(theirs, md, rx);
		cyc(6);
		`CHK(sr, theirs)
		`CHK(rx, mine)
		`CHK(ovf, 1'b1)
		`CHK(cnt, 4'h0)
	endtask

	// unit as master by toggle strobe, counting strobes
	task t_master();
		logic lvl;
		lvl = 1'b0;
		esel = 1'b0;
		ssel = 1'b1;
		dir_c = 1'b1;
		i_peer.clk_o = 1'b1;
		i_peer.dat_o = 1'b1;
		cyc(4);
		wr(8'h00, 4'h0, 1'b1, 1'b1);
		clr();
		for (int i = 0; i < 16; i++)
		begin
			tgl = 1'b1;
			cyc(1);
			tgl = 1'b0;
			cyc(9);
			lvl = ~lvl;
			`CHK(c_o, lvl)
		end
		`CHK(sr, 8'hff)
		`CHK(ovf, 1'b1)
		ssel = 1'b0;
		dir_c = 1'b0;
	endtask

	// a start pattern outside two-wire mode is ignored
	task t_det_off();
		ext = 1'b0;
		cyc(2);
		clr();
		i_peer.dat_o = 1'b0;
		cyc(8);
		`CHK(stf, 1'b0)
		i_peer.dat_o = 1'b1;
	endtask

	// start, hold, address byte, overflow hold, acknowledge
	task t_two_wire();
		logic [7:0] adr;
		adr = 8'ha4;
		dir_d = 1'b0;
		mode = 2'h2;
		ext = 1'b1;
		cyc(4);
		clr();
		i_peer.start();
		cyc(2);
		`CHK(stf, 1'b1)
		`CHK(c_oe_n, 1'b0)
		wr(8'h00, 4'h0, 1'b0, 1'b1);
		clr();
		cyc(2);
		`CHK(c_oe_n, 1'b1)
		for (int i = 7; i >= 0; i--)
			i_peer.bit_x(adr[i], s);
		cyc(2);
		`CHK(sr, adr)
		`CHK(ovf, 1'b1)
		`CHK(c_oe_n, 1'b0)
		wr(8'h00, 4'he, 1'b1, 1'b1);
		dir_d = 1'b1;
		clr();
		cyc(2);
		`CHK(c_oe_n, 1'b1)
		i_peer.bit_x(1'b1, s);
		`CHK(s, 1'b0)
		cyc(2);
		`CHK(ovf, 1'b1)
		`CHK(c_oe_n, 1'b0)
		dir_d = 1'b0;
		clr();
	endtask

	task end_of_test();
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(2);
		t_internal();
		t_spi(1'b0, 8'ha5, 8'h3c);
		t_spi(1'b1, 8'h96, 8'h71);
		t_master();
		t_det_off();
		t_two_wire();
		end_of_test();
	end
endmodule

bind usu_core usu_core_checker #(.DATA_W(DATA_W), .CNT_W(CNT_W)) i_chk (.*);
